// ===== verilog/diag_pkg.sv
// shared constants and types of the diagnostic pin reporter
package diag_pkg;

  // clock and timing
  localparam int CLK_NS = 40;
  localparam int STEP_SLOW_NS = 4000;
  localparam int STEP_FAST_NS = 1000;
  localparam int STEP_SLOW_CYC = STEP_SLOW_NS / CLK_NS;
  localparam int STEP_FAST_CYC = STEP_FAST_NS / CLK_NS;
  localparam int STEP_W = 8;
  localparam int DEB_W = 9;
  localparam int BLANK_W = 8;

  // fault set, index 0 is the highest priority
  localparam int NFAULT = 10;
  localparam int IDX_W = 4;
  localparam int F_REG_HIGH = 0;
  localparam int F_PUMP_LOW = 1;
  localparam int F_GS_LOW = 2;
  localparam int F_REG_LOW = 3;
  localparam int F_OVERHEAT = 4;
  localparam int F_MAIN_LOW = 5;
  localparam int F_MAIN_HIGH = 6;
  localparam int F_LOGIC_LOW = 7;
  localparam int F_NVM = 8;
  localparam int F_DS = 9;
  localparam int DEB_NS [NFAULT] = '{2000, 16000, 2000, 16000, 2000,
                                     8000, 2000, 8000, 0, 2000};
  localparam int BLANK_NS [4] = '{500, 1000, 2000, 4000};

  // duty codes, high steps out of an 18 step period
  localparam int DUTY_W = 5;
  localparam logic [4:0] PHASE_LAST = 5'h11;
  localparam logic [4:0] EOF_DUTY = 5'h11;
  localparam logic [49:0] DUTY_TABLE = {5'h0F, 5'h0A, 5'h09, 5'h08,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02};

  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ACTIVE = 8'h08;

  typedef logic [NFAULT-1:0] fault_vec_t;

  typedef struct packed {
    logic rate_sel;
    logic [1:0] ds_blank_sel;
    logic gs_monitor_on;
    logic ds_monitor_on;
    logic ds_bf_en;
    logic rh_bf_en;
  } ctrl_t;
  localparam logic [6:0] CTRL_RESET = 7'h2F;

  typedef enum logic [1:0] {st_idle, st_fault, st_eof} report_state_t;

  typedef struct packed {
    logic [1:0] state;
    logic drivers_on;
    fault_vec_t lock;
    fault_vec_t pend;
  } status_t;

endpackage

// ===== verilog/diag_reporter.sv
// diagnostic fault reporter on one open-drain pin, with driver disabling
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module diag_reporter (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [diag_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault sensing and driver control
  input wire diag_pkg::fault_vec_t fault_raw,
  input wire logic ds_switch,
  input wire logic en_in,
  input wire logic logic_supply_on,
  output logic drivers_on,
  // diagnostic pin
  input wire logic diag_pin_in,
  output logic diag_pin_out,
  output logic diag_pin_oe
);

  // ==========================================================
  // registers
  diag_pkg::ctrl_t ctrl_q;
  diag_pkg::fault_vec_t deb_q, deb_r_q, pend_q, lock_q;
  diag_pkg::fault_vec_t qual, rise, clr_mask, hard_mask;
  diag_pkg::report_state_t st_q, st_d;
  logic [diag_pkg::STEP_W-1:0] div_q, step_last;
  logic [diag_pkg::DUTY_W-1:0] phase_q, duty_q, duty_d;
  logic [diag_pkg::IDX_W-1:0] cur_idx_q, idx_d, first_idx;
  logic [diag_pkg::BLANK_W-1:0] blank_q, blank_load;
  logic armed_q, drivers_q, oe_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic awake, tick, high, fall_tick, period_end, ack, load;
  diag_pkg::status_t status;

  assign awake = logic_supply_on;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign drivers_on = drivers_q;
  assign diag_pin_oe = oe_q;

  // pin value is always low; high comes from the external pull-up
  always_ff @(posedge clock) begin
    diag_pin_out <= 1'b0;
  end

  // ==========================================================
  // fault qualification and debounce
  always_comb begin
    qual = fault_raw;
    qual[diag_pkg::F_DS] = fault_raw[diag_pkg::F_DS] &
      ctrl_q.ds_monitor_on & (blank_q == '0);
    qual[diag_pkg::F_GS_LOW] = fault_raw[diag_pkg::F_GS_LOW] &
      ctrl_q.gs_monitor_on;
  end
  always_comb begin
    blank_load = '0;
    for (int b = 0; b < 4; b++) begin
      if (ctrl_q.ds_blank_sel == b[1:0]) begin
        blank_load = diag_pkg::BLANK_W'((diag_pkg::BLANK_NS[b] +
          diag_pkg::CLK_NS - 1) / diag_pkg::CLK_NS);
      end
    end
  end

  // blanking restarts at each switching event
  always_ff @(posedge clock) begin
    if (!nrst || !awake) begin
      blank_q <= '0;
    end else if (ds_switch) begin
      blank_q <= blank_load;
    end else if (blank_q != '0) begin
      blank_q <= blank_q - 1'b1;
    end
  end

  for (genvar i = 0; i < diag_pkg::NFAULT; i++) begin : g_deb
    localparam int LIM = (diag_pkg::DEB_NS[i] + diag_pkg::CLK_NS - 1) /
      diag_pkg::CLK_NS;
    logic [diag_pkg::DEB_W-1:0] cnt_q;
    // condition must hold for the whole debounce time
    always_ff @(posedge clock) begin
      if (!nrst || !awake || !qual[i]) begin
        cnt_q <= '0;
        deb_q[i] <= 1'b0;
      end else begin
        if (cnt_q < diag_pkg::DEB_W'(LIM)) begin
          cnt_q <= cnt_q + 1'b1;
        end
        deb_q[i] <= (cnt_q >= diag_pkg::DEB_W'(LIM));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !awake) begin
      deb_r_q <= '0;
    end else begin
      deb_r_q <= deb_q;
    end
  end
  assign rise = deb_q & ~deb_r_q;

  // ==========================================================
  // pwm timing
  assign step_last = ctrl_q.rate_sel ?
    diag_pkg::STEP_W'(diag_pkg::STEP_FAST_CYC - 1) :
    diag_pkg::STEP_W'(diag_pkg::STEP_SLOW_CYC - 1);
  assign tick = (div_q == step_last);
  assign high = (phase_q < duty_q);
  assign fall_tick = tick && (phase_q == duty_q - 5'h01);
  assign period_end = tick && (phase_q == diag_pkg::PHASE_LAST);
  // host low at our falling edge after release seen high
  assign ack = (st_q != diag_pkg::st_idle) && fall_tick && !diag_pin_in &&
    armed_q;

  always_comb begin
    first_idx = '0;
    for (int k = diag_pkg::NFAULT - 1; k >= 0; k--) begin
      if (pend_q[k] && !clr_mask[k]) begin
        first_idx = diag_pkg::IDX_W'(k);
      end
    end
  end
  always_comb begin
    clr_mask = '0;
    if (ack && st_q == diag_pkg::st_fault) begin
      clr_mask[cur_idx_q] = 1'b1;
    end
  end

  // ==========================================================
  // report sequencing
  always_comb begin
    st_d = st_q;
    load = 1'b0;
    case (st_q)
      diag_pkg::st_idle: begin
        if (|pend_q) begin
          st_d = diag_pkg::st_fault;
          load = 1'b1;
        end
      end
      diag_pkg::st_fault: begin
        if (ack) begin
          load = 1'b1;
          if (|(pend_q & ~clr_mask)) begin
            st_d = diag_pkg::st_fault;
          end else begin
            st_d = diag_pkg::st_eof;
          end
        end
      end
      diag_pkg::st_eof: begin
        if (ack) begin
          load = 1'b1;
          if (|pend_q) begin
            st_d = diag_pkg::st_fault;
          end else if (|deb_q) begin
            st_d = diag_pkg::st_eof;
          end else begin
            st_d = diag_pkg::st_idle;
          end
        end else if (period_end && |pend_q) begin
          st_d = diag_pkg::st_fault;
          load = 1'b1;
        end
      end
      default: begin
        st_d = diag_pkg::st_idle;
      end
    endcase
  end
  assign idx_d = first_idx;
  assign duty_d = (st_d == diag_pkg::st_fault) ?
    diag_pkg::DUTY_TABLE[idx_d*diag_pkg::DUTY_W +: diag_pkg::DUTY_W] :
    diag_pkg::EOF_DUTY;
  always_ff @(posedge clock) begin
    if (!nrst || !awake) begin
      st_q <= diag_pkg::st_idle;
      cur_idx_q <= '0;
      duty_q <= '0;
    end else begin
      st_q <= st_d;
      if (load) begin
        cur_idx_q <= idx_d;
        duty_q <= duty_d;
      end
    end
  end
  // period counters, restarted at each new code
  always_ff @(posedge clock) begin
    if (!nrst || !awake || load || st_q == diag_pkg::st_idle) begin
      div_q <= '0;
      phase_q <= '0;
    end else if (tick) begin
      div_q <= '0;
      if (phase_q == diag_pkg::PHASE_LAST) begin
        phase_q <= '0;
      end else begin
        phase_q <= phase_q + 1'b1;
      end
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // one acknowledge per hold: rearm only after the pin is seen high
  always_ff @(posedge clock) begin
    if (!nrst || !awake || load) begin
      armed_q <= 1'b0;
    end else if (!oe_q && diag_pin_in) begin
      armed_q <= 1'b1;
    end
  end

  // pending faults: a new event beats an acknowledge clear
  always_ff @(posedge clock) begin
    if (!nrst || !awake) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~clr_mask) | rise;
    end
  end

  // ==========================================================
  // pin and gate drivers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      oe_q <= 1'b0;
    end else if (!awake) begin
      oe_q <= 1'b1;
    end else if (st_q == diag_pkg::st_idle) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !high;
    end
  end
  always_comb begin
    hard_mask = '0;
    hard_mask[diag_pkg::F_MAIN_HIGH] = 1'b1;
    hard_mask[diag_pkg::F_REG_HIGH] = ctrl_q.rh_bf_en;
    hard_mask[diag_pkg::F_DS] = ctrl_q.ds_bf_en;
  end

  always_ff @(posedge clock) begin
    if (!nrst || !awake) begin
      lock_q <= '0;
    end else begin
      lock_q <= (lock_q & ~clr_mask) | (rise & hard_mask);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      drivers_q <= 1'b0;
    end else begin
      drivers_q <= en_in && awake && !(|lock_q);
    end
  end

  // ==========================================================
  // apb slave, answers one cycle into the access phase
  assign status = '{state: st_q, drivers_on: drivers_q, lock: lock_q,
    pend: pend_q};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      ctrl_q <= diag_pkg::CTRL_RESET;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (paddr == diag_pkg::ADDR_CTRL) begin
        if (pwrite) begin
          ctrl_q <= pwdata[6:0];
        end else begin
          prdata_q <= {25'h0000000, ctrl_q};
        end
      end else if (paddr == diag_pkg::ADDR_STATUS) begin
        if (!pwrite) begin
          prdata_q <= {9'h000, status};
        end
      end else if (paddr == diag_pkg::ADDR_ACTIVE) begin
        if (!pwrite) begin
          prdata_q <= {22'h000000, deb_q};
        end
      end else begin
        pslverr_q <= 1'b1;
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  idle_high_a: assert property ((st_q == diag_pkg::st_idle &&
    awake) ##1 awake |-> !oe_q) else $error("pin driven while idle");
  sleep_low_a: assert property (!awake |=> oe_q)
    else $error("pin not low in sleep");
  drv_off_a: assert property ((!awake || !en_in) |=> !drivers_q)
    else $error("drivers on while disabled");
  drv_on_a: assert property ((en_in && awake && lock_q == '0)
    |=> drivers_q) else $error("drivers not reenabled");
  lock_off_a: assert property ((|lock_q) |=> !drivers_q)
    else $error("drivers on during hard fault");
  ack_clear_a: assert property ((ack && st_q == diag_pkg::st_fault &&
    !rise[cur_idx_q]) |=> !pend_q[$past(cur_idx_q)])
    else $error("acknowledged fault still pending");
  first_pick_a: assert property ((st_q == diag_pkg::st_idle &&
    |pend_q && awake) ##1 awake |-> cur_idx_q == $past(first_idx))
    else $error("wrong fault order");
  eof_code_a: assert property ((st_q == diag_pkg::st_eof) |->
    duty_q == diag_pkg::EOF_DUTY) else $error("bad end code");
  repeat_a: assert property ((st_q == diag_pkg::st_fault &&
    period_end && !ack && awake) |=> st_q == diag_pkg::st_fault &&
    phase_q == 5'h00) else $error("code not repeated");
  ds_mask_a: assert property (!ctrl_q.ds_monitor_on |=>
    !deb_q[diag_pkg::F_DS]) else $error("masked ds fault");
  nvm_fast_a: assert property ((fault_raw[diag_pkg::F_NVM] && awake)
    ##1 awake |-> deb_q[diag_pkg::F_NVM])
    else $error("memory error delayed");
  fault_seen_c: cover property (st_q == diag_pkg::st_idle
    ##1 st_q == diag_pkg::st_fault);
  ack_seen_c: cover property (ack && st_q == diag_pkg::st_fault);
  eof_done_c: cover property (st_q == diag_pkg::st_eof ##1
    st_q == diag_pkg::st_idle);
  sleep_c: cover property (!awake ##1 awake);
endmodule

// ===== testbench/host_model.sv
// host side model: decodes pin duty and sends acknowledgements
`timescale 1ns/1ps

module host_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // wire and commands
  input wire logic wire_level,
  input wire logic ack_req,
  input wire logic [11:0] hold_cyc,
  // results
  output logic host_pull,
  output logic [11:0] high_len,
  output logic [15:0] falls
);
  logic [11:0] run_q;
  logic [11:0] hold_q;
  logic last_q;

  // ==========================================================
  // duty decode: high run length before each fall
  always_ff @(posedge clock) begin
    last_q <= wire_level;
    run_q <= wire_level ? run_q + 12'h001 : 12'h000;
    if (!nrst) begin
      falls <= 16'h0000;
      high_len <= 12'h000;
    end else if (last_q && !wire_level) begin
      falls <= falls + 16'h0001;
      high_len <= run_q;
    end
  end

  // ==========================================================
  // acknowledge: pull low for the commanded span, then release
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hold_q <= 12'h000;
    end else if (ack_req && hold_q == 12'h000) begin
      hold_q <= hold_cyc;
    end else if (hold_q != 12'h000) begin
      hold_q <= hold_q - 12'h001;
    end
  end
  assign host_pull = hold_q != 12'h000;
endmodule

// ===== testbench/diag_reporter_test.sv
// self-checking bench for the diagnostic pin reporter
`timescale 1ns/1ps

module diag_reporter_test;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [9:0] mask;
    logic [4:0] duty;
    logic lock;
  } row_t;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  diag_pkg::fault_vec_t fault_raw = '0;
  logic ds_switch = 1'b0;
  logic en_in = 1'b1;
  logic logic_supply_on = 1'b1;
  logic drivers_on;
  logic pin_out;
  logic pin_oe;
  logic host_pull;
  logic ack_req = 1'b0;
  logic [11:0] hold_cyc = 12'h000;
  logic [11:0] high_len;
  logic [15:0] falls;
  logic pin;
  int n_fail = 0;
  int samples_checked = 0;
  int st;
  logic [31:0] rd;
  logic [31:0] want;
  logic err;
  row_t rows [10];

  assign pin = !(pin_oe | host_pull);

  always #20 clock = ~clock;

  diag_reporter diag_reporter_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_raw(fault_raw),
    .ds_switch(ds_switch), .en_in(en_in),
    .logic_supply_on(logic_supply_on), .drivers_on(drivers_on),
    .diag_pin_in(pin), .diag_pin_out(pin_out), .diag_pin_oe(pin_oe)
  );

  host_model host_model_inst (
    .clock(clock), .nrst(nrst), .wire_level(pin), .ack_req(ack_req),
    .hold_cyc(hold_cyc), .host_pull(host_pull), .high_len(high_len),
    .falls(falls)
  );

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_falls(input int k);
    logic [15:0] s;
    int n;
    s = falls;
    n = 0;
    while (16'(falls - s) < k && n < 8000) begin
      @(posedge clock);
      n++;
    end
    check(n, 32'(n) % 8000);
  endtask

  task automatic code(input logic [4:0] duty, input int step);
    wait_falls(2);
    check({20'h0, high_len}, 32'(duty) * step);
  endtask

  task automatic ack(input int h);
    hold_cyc <= 12'(h);
    ack_req <= 1'b1;
    @(posedge clock);
    ack_req <= 1'b0;
    repeat (h + 2) @(posedge clock);
  endtask

  task automatic quiet();
    logic [15:0] s;
    s = falls;
    repeat (1000) @(posedge clock);
    check(falls, s);
    check(pin, 1'b1);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #4000000;
    n_fail++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    rows = '{{7'h2F, 10'h001, 5'h02, 1'b1}, {7'h6F, 10'h002, 5'h03, 1'b0},
             {7'h6F, 10'h004, 5'h04, 1'b0}, {7'h6F, 10'h008, 5'h05, 1'b0},
             {7'h6F, 10'h010, 5'h06, 1'b0}, {7'h6F, 10'h020, 5'h07, 1'b0},
             {7'h6F, 10'h040, 5'h08, 1'b1}, {7'h6F, 10'h080, 5'h09, 1'b0},
             {7'h6F, 10'h100, 5'h0A, 1'b0}, {7'h6F, 10'h200, 5'h0F, 1'b1}};
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    ds_switch <= 1'b1;
    @(posedge clock);
    ds_switch <= 1'b0;
    apb(1'b0, diag_pkg::ADDR_CTRL, 32'h00000000);
    check(rd, 32'h0000002F);
    check(pin, 1'b1);
    apb(1'b0, 8'h0C, 32'h00000000);
    check({rd[30:0], err}, 32'h00000001);
    for (int i = 0; i < 10; i++) begin
      st = rows[i].ctrl[6] ? diag_pkg::STEP_FAST_CYC
                           : diag_pkg::STEP_SLOW_CYC;
      apb(1'b1, diag_pkg::ADDR_CTRL, {25'h0, rows[i].ctrl});
      fault_raw <= rows[i].mask;
      code(rows[i].duty, st);
      check(drivers_on, !rows[i].lock);
      apb(1'b0, diag_pkg::ADDR_STATUS, 32'h00000000);
      want = {9'h000, 2'b01, ~rows[i].lock,
              rows[i].mask & {10{rows[i].lock}}, rows[i].mask};
      check(rd, want);
      fault_raw <= '0;
      ack(18 * st + 50);
      code(diag_pkg::EOF_DUTY, st);
      check(drivers_on, 1'b1);
      ack(18 * st + 50);
      quiet();
    end
    // simultaneous faults
    fault_raw <= 10'h011;
    code(5'h02, 25);
    ack(500);
    code(5'h06, 25);
    fault_raw <= '0;
    ack(500);
    code(diag_pkg::EOF_DUTY, 25);
    ack(500);
    quiet();
    // both monitors off
    apb(1'b1, diag_pkg::ADDR_CTRL, 32'h00000063);
    fault_raw <= 10'h204;
    quiet();
    apb(1'b0, diag_pkg::ADDR_ACTIVE, 32'h00000000);
    check(rd, 32'h00000000);
    fault_raw <= '0;
    // enable pin and sleep
    en_in <= 1'b0;
    repeat (3) @(posedge clock);
    check(drivers_on, 1'b0);
    en_in <= 1'b1;
    repeat (3) @(posedge clock);
    check(drivers_on, 1'b1);
    logic_supply_on <= 1'b0;
    repeat (3) @(posedge clock);
    check(pin, 1'b0);
    check(pin_out, 1'b0);
    check(drivers_on, 1'b0);
    logic_supply_on <= 1'b1;
    repeat (3) @(posedge clock);
    check(pin, 1'b1);
    check(drivers_on, 1'b1);
    quiet();
    // reset in the middle of a report
    fault_raw <= 10'h020;
    code(5'h07, diag_pkg::STEP_FAST_CYC);
    nrst <= 1'b0;
    fault_raw <= '0;
    repeat (2) @(posedge clock);
    check(pin, 1'b1);
    check(drivers_on, 1'b0);
    nrst <= 1'b1;
    apb(1'b0, diag_pkg::ADDR_CTRL, 32'h00000000);
    check(rd, 32'h0000002F);
    quiet();
    print_verdict();
  end
endmodule
